// >>> pss_top.sv
// pss_top.sv - pattern step sequencer with axi4-lite register access
//
// Functional notes
// - at end address reload loop return address
// - loop length is one plus end minus return
// - run entry loads start, shows its word
// - mode 0 runs without any trigger
// - modes 1/3 every loop waits level/edge trigger
// - modes 2/4 first loop free, later triggered
// - polarity 0 active low, 1 active high
// - trigger comes from dedicated trigger pin
// - first step 13 stimulus, 10 capture periods
// - level modes double end step when held
// - static value drives outputs until run starts
// - output disable 1 tri-states pattern outputs
// - memory access when idle uses counter, then increments it
`timescale 1ns/1ps
module pss_top #(
    parameter int ADDR_W = 10,
    parameter int PAT_W = 8,
    parameter int DIV_W = 24
) (
    input wire logic clk_sys, // 25 mhz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [7:0] s_axi_awaddr, // write byte address
    input wire logic [2:0] s_axi_awprot, // unused protection
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [7:0] s_axi_araddr, // read byte address
    input wire logic [2:0] s_axi_arprot, // unused protection
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    input wire logic trig_pin, // dedicated pattern trigger pin
    output logic [PAT_W-1:0] pattern_out, // pattern output value
    output logic pattern_oe // high while pattern outputs drive
);
    // one word per counter value
    localparam int DEPTH = 1 << ADDR_W;

    initial begin
        if (ADDR_W < 2 || ADDR_W > 16) $error("pss_top: ADDR_W out of range");
        if (PAT_W < 1 || PAT_W > 32) $error("pss_top: PAT_W out of range");
        if (DIV_W < 1 || DIV_W > 32) $error("pss_top: DIV_W out of range");
    end

    // ==========================================================
    // state
    // no reset: load before a run
    logic [PAT_W-1:0] mem [DEPTH];
    logic [31:0] ctrl;
    logic [ADDR_W-1:0] run_start_address;
    logic [ADDR_W-1:0] loop_end_address;
    logic [ADDR_W-1:0] loop_return_address;
    logic [ADDR_W-1:0] step_address_counter;
    logic [PAT_W-1:0] static_output_value;
    logic [DIV_W-1:0] clock_prescale_divider;
    pss_pkg::pss_state_e state;
    logic [4:0] lat_cnt;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    logic [31:0] next_ctrl;
    logic [ADDR_W-1:0] next_start, next_end, next_ret, next_addr;
    logic [PAT_W-1:0] next_static, next_pattern_out;
    logic [DIV_W-1:0] next_div;
    pss_pkg::pss_state_e next_state;
    logic [4:0] next_lat_cnt;
    logic next_aw_held, next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid, next_oe;
    logic [1:0] next_bresp, next_rresp;
    logic mem_we;
    logic [31:0] wmask;

    logic tick, trig_level, trig_edge;
    logic run_on, capture, edge_mode, later_mode;
    logic [2:0] mode;
    logic do_write, do_read, trig_event;

    // ==========================================================
    // helpers
    pss_prescaler #(.DIV_W(DIV_W)) u_prescaler (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .divide_m1(clock_prescale_divider),
        .tick(tick)
    );

    pss_trig_detect u_trig (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .trig_pin(trig_pin),
        .polarity(ctrl[pss_pkg::CTRL_POL]),
        .tick(tick),
        .trig_level(trig_level),
        .trig_edge(trig_edge)
    );

    // ==========================================================
    // decoded control; unknown mode codes behave as free running
    always_comb begin
        run_on = ctrl[pss_pkg::CTRL_RUN];
        capture = ctrl[pss_pkg::CTRL_CAPTURE];
        mode = ctrl[pss_pkg::CTRL_MODE_HI:pss_pkg::CTRL_MODE_LO];
        edge_mode = (mode == pss_pkg::MODE_EDGE_ALL) || (mode == pss_pkg::MODE_EDGE_LATER);
        later_mode = (mode == pss_pkg::MODE_LEVEL_LATER) || (mode == pss_pkg::MODE_EDGE_LATER);
        trig_event = edge_mode ? trig_edge : (tick && trig_level);
        // strobes only matter for ctrl
        wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
        do_write = aw_held && w_held && !s_axi_bvalid;
        do_read = s_axi_arvalid && s_axi_arready;
    end

    // ==========================================================
    // axi handshake and register writes
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_ctrl = ctrl;
        next_start = run_start_address;
        next_end = loop_end_address;
        next_ret = loop_return_address;
        next_static = static_output_value;
        next_div = clock_prescale_divider;
        mem_we = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = pss_pkg::RESP_OKAY;
            unique case (aw_addr)
                pss_pkg::OFS_CTRL: next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
                pss_pkg::OFS_START: next_start = w_data[ADDR_W-1:0];
                pss_pkg::OFS_END: next_end = w_data[ADDR_W-1:0];
                pss_pkg::OFS_RET: next_ret = w_data[ADDR_W-1:0];
                pss_pkg::OFS_ADDR, pss_pkg::OFS_STATUS: ;
                pss_pkg::OFS_MEM: mem_we = (state == pss_pkg::PSS_IDLE);
                pss_pkg::OFS_STATIC: next_static = w_data[PAT_W-1:0];
                pss_pkg::OFS_DIV: next_div = w_data[DIV_W-1:0];
                default: next_bresp = pss_pkg::RESP_SLVERR;
            endcase
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = pss_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                pss_pkg::OFS_CTRL: next_rdata = ctrl;
                pss_pkg::OFS_START: next_rdata[ADDR_W-1:0] = run_start_address;
                pss_pkg::OFS_END: next_rdata[ADDR_W-1:0] = loop_end_address;
                pss_pkg::OFS_RET: next_rdata[ADDR_W-1:0] = loop_return_address;
                pss_pkg::OFS_ADDR: next_rdata[ADDR_W-1:0] = step_address_counter;
                pss_pkg::OFS_MEM: next_rdata[PAT_W-1:0] = mem[step_address_counter];
                pss_pkg::OFS_STATIC: next_rdata[PAT_W-1:0] = static_output_value;
                pss_pkg::OFS_DIV: next_rdata[DIV_W-1:0] = clock_prescale_divider;
                pss_pkg::OFS_STATUS: next_rdata[4:0] = state;
                default: next_rresp = pss_pkg::RESP_SLVERR;
            endcase
        end
        // one write answered at a time
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // ==========================================================
    // sequencer and step address counter
    always_comb begin
        next_state = state;
        next_addr = step_address_counter;
        next_lat_cnt = lat_cnt;
        next_pattern_out = pattern_out;
        next_oe = !ctrl[pss_pkg::CTRL_OUT_DIS];
        unique case (state)
            pss_pkg::PSS_IDLE: begin
                next_pattern_out = static_output_value;
                // host owns the counter when idle
                if (do_write && aw_addr == pss_pkg::OFS_ADDR) begin
                    next_addr = w_data[ADDR_W-1:0];
                end else if ((do_write && aw_addr == pss_pkg::OFS_MEM) ||
                             (do_read && s_axi_araddr == pss_pkg::OFS_MEM)) begin
                    next_addr = step_address_counter + 1'b1;
                end
                if (run_on) begin
                    next_addr = run_start_address;
                    next_pattern_out = mem[run_start_address];
                    if (mode == pss_pkg::MODE_LEVEL_ALL || mode == pss_pkg::MODE_EDGE_ALL) begin
                        next_state = pss_pkg::PSS_ARM;
                    end else begin
                        next_state = pss_pkg::PSS_RUN;
                    end
                end
            end
            pss_pkg::PSS_ARM: begin
                // waits for the first trigger, then counts the fixed latency
                if (trig_event) begin
                    next_state = pss_pkg::PSS_LAT;
                    next_lat_cnt = capture ? pss_pkg::LAT_CAPTURE : pss_pkg::LAT_STIMULUS;
                end
            end
            pss_pkg::PSS_LAT: begin
                // in ticks: scales with the divider
                if (tick) begin
                    next_lat_cnt = lat_cnt - 1'b1;
                    if (lat_cnt == 5'h01) begin
                        next_state = pss_pkg::PSS_RUN;
                    end
                end
            end
            pss_pkg::PSS_RUN: begin
                if (tick) begin
                    if (step_address_counter == loop_end_address) begin
                        if (mode == pss_pkg::MODE_FREE || mode > pss_pkg::MODE_EDGE_LATER) begin
                            next_addr = loop_return_address;
                            next_pattern_out = mem[loop_return_address];
                        end else begin
                            // end word stays out while the next trigger is awaited
                            next_state = pss_pkg::PSS_WAIT;
                        end
                    end else begin
                        next_addr = step_address_counter + 1'b1;
                        next_pattern_out = mem[step_address_counter + 1'b1];
                    end
                end
            end
            pss_pkg::PSS_WAIT: begin
                // a held level trigger is seen one period late, doubling the end step
                if (trig_event) begin
                    next_state = pss_pkg::PSS_RUN;
                    next_addr = loop_return_address;
                    next_pattern_out = mem[loop_return_address];
                end
            end
            default: next_state = pss_pkg::PSS_IDLE;
        endcase
        if (!run_on) begin
            next_state = pss_pkg::PSS_IDLE;
        end
    end

    // ==========================================================
    // registers
    // outputs all leave flip-flops
    // same counter as the host read
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[step_address_counter] <= w_data[PAT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= pss_pkg::CTRL_RESET;
            run_start_address <= '0;
            loop_end_address <= '0;
            loop_return_address <= '0;
            step_address_counter <= '0;
            static_output_value <= '0;
            clock_prescale_divider <= pss_pkg::DIV_RESET;
            state <= pss_pkg::PSS_IDLE;
            lat_cnt <= '0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pss_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= pss_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            pattern_out <= '0;
            pattern_oe <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            run_start_address <= next_start;
            loop_end_address <= next_end;
            loop_return_address <= next_ret;
            step_address_counter <= next_addr;
            static_output_value <= next_static;
            clock_prescale_divider <= next_div;
            state <= next_state;
            lat_cnt <= next_lat_cnt;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            pattern_out <= next_pattern_out;
            pattern_oe <= next_oe;
        end
    end
endmodule

// >>> pss_pkg.sv
// pss_pkg.sv - constants shared by the pattern step sequencer files
package pss_pkg;
    // ==========================================================
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_END = 8'h08;
    localparam logic [7:0] OFS_RET = 8'h0c;
    localparam logic [7:0] OFS_ADDR = 8'h10;
    localparam logic [7:0] OFS_MEM = 8'h14;
    localparam logic [7:0] OFS_STATIC = 8'h18;
    localparam logic [7:0] OFS_DIV = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // ==========================================================
    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CAPTURE = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_MODE_HI = 6;
    localparam int CTRL_OUT_DIS = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [23:0] DIV_RESET = 24'h00_0000;
    // ==========================================================
    // trigger modes and latencies in pattern input clock periods
    localparam logic [2:0] MODE_FREE = 3'h0;
    localparam logic [2:0] MODE_LEVEL_ALL = 3'h1;
    localparam logic [2:0] MODE_LEVEL_LATER = 3'h2;
    localparam logic [2:0] MODE_EDGE_ALL = 3'h3;
    localparam logic [2:0] MODE_EDGE_LATER = 3'h4;
    localparam logic [4:0] LAT_STIMULUS = 5'h0d;
    localparam logic [4:0] LAT_CAPTURE = 5'h0a;
    // ==========================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [4:0] {
        PSS_IDLE = 5'b00001,
        PSS_ARM = 5'b00010,
        PSS_LAT = 5'b00100,
        PSS_RUN = 5'b01000,
        PSS_WAIT = 5'b10000
    } pss_state_e;
endpackage

// >>> pss_trig_detect.sv
// pss_trig_detect.sv - trigger pin synchroniser with level and edge detection
`timescale 1ns/1ps
module pss_trig_detect (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic trig_pin, // dedicated trigger pin, asynchronous
    input wire logic polarity, // 1 active high, 0 active low
    input wire logic tick, // one pulse per pattern input clock period
    output logic trig_level, // trigger active, synchronised
    output logic trig_edge // pulse with tick on an inactive to active change
);
    logic sync_1;
    logic sync_2;
    logic prev_active;
    logic next_prev_active;

    // ==========================================================
    // synchroniser: nothing but sync_2 reads sync_1
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            prev_active <= 1'b0;
        end else begin
            sync_1 <= trig_pin;
            sync_2 <= sync_1;
            prev_active <= next_prev_active;
        end
    end

    // ==========================================================
    // edges are judged at the step rate, so a level must last one period
    always_comb begin
        trig_level = (sync_2 == polarity);
        next_prev_active = tick ? trig_level : prev_active;
        trig_edge = tick && trig_level && !prev_active;
    end
endmodule

// >>> pss_prescaler.sv
// pss_prescaler.sv - divides the system clock into pattern input clock ticks
`timescale 1ns/1ps
module pss_prescaler #(
    parameter int DIV_W = 24
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [DIV_W-1:0] divide_m1, // divider value minus one
    output logic tick // one cycle pulse every divide_m1+1 cycles
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic next_tick;

    initial begin
        if (DIV_W < 1 || DIV_W > 32) $error("pss_prescaler: DIV_W out of range");
    end

    always_comb begin
        if (count >= divide_m1) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 1'b1;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

// >>> pss_top_assertions.sv
// bus and pattern output checks for the pattern step sequencer
`timescale 1ns/1ps
module pss_top_assertions #(
    parameter int PAT_W = 8
) (
    input wire logic clk_sys, // clock
    input wire logic rst_b, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [7:0] s_axi_awaddr, // aw address
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [PAT_W-1:0] pattern_out, // pattern value
    input wire logic pattern_oe // pattern driven
);
    // ==========================================================
    // last write seen, so a response can be tied to its cause
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic run_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            run_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && aw_q == pss_pkg::OFS_CTRL) run_q <= w_q[0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[2:3] s_axi_bvalid) else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    write_resp_a: assert property ($rose(s_axi_bvalid) && aw_q != pss_pkg::OFS_STATUS
        |-> s_axi_bresp == ((aw_q > pss_pkg::OFS_STATUS || aw_q[1:0] != 2'h0)
        ? pss_pkg::RESP_SLVERR : pss_pkg::RESP_OKAY)) else $error("wrong write response");
    oe_follow_a: assert property ($rose(s_axi_bvalid) && aw_q == pss_pkg::OFS_CTRL
        |-> ##[0:2] pattern_oe == !w_q[8]) else $error("output enable not following");
    static_show_a: assert property ($rose(s_axi_bvalid) && aw_q == pss_pkg::OFS_STATIC
        && !run_q |-> ##[0:2] pattern_out == w_q[PAT_W-1:0]) else $error("static not shown");
endmodule

// >>> pss_dut_model.sv
// far-side model: trigger source and receiver of the pattern outputs
`timescale 1ns/1ps
module pss_dut_model (
    input wire logic clk_sys, // clock
    input wire logic trig_req, // bench asks for an active trigger
    input wire logic polarity, // 1 active high, 0 active low
    input wire logic [7:0] pattern_out, // pattern from sequencer
    input wire logic pattern_oe, // pattern driven
    output logic trig_pin, // dedicated trigger pin
    output logic [7:0] seen // word received last clock
);
    initial trig_pin = 1'b0;
    initial seen = 8'h00;
    // pin moves only on clock edges, so every level lasts at least one clock
    always @(posedge clk_sys) trig_pin <= polarity ? trig_req : !trig_req;
    // a released bus gives no stale word
    always @(posedge clk_sys) seen <= pattern_oe ? pattern_out : ~seen;
endmodule

// >>> pss_top_tb_top.sv
// self-checking bench for the pattern step sequencer
`timescale 1ns/1ps
module pss_top_tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, trq = 1'b0, pol = 1'b1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic awr, wr_rdy, bv, arr, rv, oe, tpin;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [7:0] pout, seen;
    logic [7:0] mw [3] = '{8'h3c, 8'h5a, 8'h96};
    int num_errors = 0, cmp_count = 0, n = 0;
    initial forever #20 clk_sys = ~clk_sys;
    pss_top u_pss_top (.clk_sys, .rst_b, .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .trig_pin(tpin), .pattern_out(pout), .pattern_oe(oe));
    pss_dut_model u_pss_dut_model (.clk_sys, .trig_req(trq), .polarity(pol),
        .pattern_out(pout), .pattern_oe(oe), .trig_pin(tpin), .seen(seen));
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk_sys);
            if (!ad && awr === 1'b1) begin ad = 1'b1; awv <= 1'b0; end
            if (!dd && wr_rdy === 1'b1) begin dd = 1'b1; wv <= 1'b0; end
        end
        @(posedge clk_sys);
        while (bv !== 1'b1) @(posedge clk_sys);
        chk("bresp", 32'(br), (a > 8'h20) ? 32'h2 : 32'h0);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        ara <= a;
        arv <= 1'b1;
        @(posedge clk_sys);
        while (arr !== 1'b1) @(posedge clk_sys);
        arv <= 1'b0;
        @(posedge clk_sys);
        while (rv !== 1'b1) @(posedge clk_sys);
        chk(nm, rd, e);
        chk("rresp", 32'(rr), (a > 8'h20) ? 32'h2 : 32'h0);
    endtask
    task automatic wait_seen(input logic [7:0] e, input int lim);
        n = 0;
        while (seen !== e && n < lim) begin @(posedge clk_sys); n++; end
        chk("reach", 32'(seen), 32'(e));
    endtask
    task automatic seq(input logic [7:0] e[6]);
        foreach (e[i]) begin @(posedge clk_sys); chk("step", 32'(seen), 32'(e[i])); end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #800000;
        num_errors++;
        tally_and_finish;
    end
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk("ctrl", pss_pkg::OFS_CTRL, pss_pkg::CTRL_RESET);
        rd_chk("div", pss_pkg::OFS_DIV, 32'(pss_pkg::DIV_RESET));
        rd_chk("status", pss_pkg::OFS_STATUS, 32'h0000_0001);
        wr(8'h40, 32'h0000_0000);
        wr(pss_pkg::OFS_ADDR, 32'h0000_0000);
        foreach (mw[i]) wr(pss_pkg::OFS_MEM, 32'(mw[i]));
        rd_chk("addr", pss_pkg::OFS_ADDR, 32'h0000_0003);
        wr(pss_pkg::OFS_ADDR, 32'h0000_0001);
        rd_chk("mem", pss_pkg::OFS_MEM, 32'(mw[1]));
        rd_chk("addr", pss_pkg::OFS_ADDR, 32'h0000_0002);
        wr(pss_pkg::OFS_START, 32'h0000_0000);
        wr(pss_pkg::OFS_END, 32'h0000_0002);
        wr(pss_pkg::OFS_RET, 32'h0000_0001);
        wr(pss_pkg::OFS_STATIC, 32'h0000_00e7);
        repeat (2) @(posedge clk_sys);
        chk("static", 32'(pout), 32'h0000_00e7);
        wr(pss_pkg::OFS_CTRL, 32'h0000_0100);
        repeat (2) @(posedge clk_sys);
        chk("oe", 32'(oe), 32'h0000_0000);
        // free run, one step every two clocks
        wr(pss_pkg::OFS_DIV, 32'h0000_0001);
        wr(pss_pkg::OFS_CTRL, 32'h0000_0001);
        @(posedge clk_sys);
        chk("oe", 32'(oe), 32'h0000_0001);
        wait_seen(mw[1], 40);
        seq('{8'h5a, 8'h96, 8'h96, 8'h5a, 8'h5a, 8'h96});
        wr(pss_pkg::OFS_CTRL, 32'h0000_0000);
        wr(pss_pkg::OFS_DIV, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        chk("static", 32'(pout), 32'h0000_00e7);
        // level trigger held, stimulus then capture latency
        for (int c = 0; c < 2; c++) begin
            wr(pss_pkg::OFS_CTRL, 32'h0000_0015 + 32'(2 * c));
            wait_seen(mw[0], 10);
            repeat (5) @(posedge clk_sys);
            chk("armed", 32'(seen), 32'(mw[0]));
            trq <= 1'b1;
            n = 0;
            while (seen === mw[0] && n < 40) begin @(posedge clk_sys); n++; end
            chk("lat", 32'(n >= (c ? 16 : 19) && n <= (c ? 18 : 21)), 32'h1);
            chk("first", 32'(seen), 32'(mw[1]));
            seq('{8'h96, 8'h96, 8'h5a, 8'h96, 8'h96, 8'h5a});
            trq <= 1'b0;
            wr(pss_pkg::OFS_CTRL, 32'h0000_0000);
        end
        // edge trigger after a free first loop, active low pin
        pol <= 1'b0;
        wr(pss_pkg::OFS_CTRL, 32'h0000_0041);
        wait_seen(mw[2], 20);
        repeat (20) @(posedge clk_sys);
        chk("hold", 32'(seen), 32'(mw[2]));
        trq <= 1'b1;
        repeat (2) @(posedge clk_sys);
        trq <= 1'b0;
        wait_seen(mw[1], 40);
        wr(pss_pkg::OFS_CTRL, 32'h0000_0000);
        tally_and_finish;
    end
endmodule
bind pss_top pss_top_assertions #(.PAT_W(PAT_W)) u_chk (.clk_sys, .rst_b, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .pattern_out, .pattern_oe);
